// ===== logic/cpm_pkg.sv
package cpm_pkg;

  // Register indices; each register is one byte at its own address.
  localparam logic [2:0] CPM_ADDR_CTRL = 3'h0;
  localparam logic [2:0] CPM_ADDR_DUTY = 3'h1;
  localparam logic [2:0] CPM_ADDR_SHADOW = 3'h2;
  localparam logic [2:0] CPM_ADDR_PERIOD = 3'h3;
  localparam logic [2:0] CPM_ADDR_COUNT = 3'h4;
  localparam logic [2:0] CPM_ADDR_TCTRL = 3'h5;
  localparam logic [2:0] CPM_ADDR_STATUS = 3'h6;
  localparam logic [2:0] CPM_ADDR_PINCTL = 3'h7;

  // Field positions.
  localparam int CPM_MODE_LSB = 0;
  localparam int CPM_DLOW_LSB = 4;
  localparam int CPM_TON_BIT = 2;
  localparam int CPM_FLAG_BIT = 0;
  localparam int CPM_DRV_BIT = 0;

  // Reset values.
  localparam logic [7:0] CPM_RST_BYTE = 8'h00;
  localparam logic [7:0] CPM_RST_PERIOD = 8'hff;
  localparam logic [1:0] CPM_RST_LOW = 2'h0;
  localparam logic [3:0] CPM_RST_NIB = 4'h0;

  // Mode codes of the mode select field.
  localparam logic [3:0] CPM_M_OFF = 4'h0;
  localparam logic [3:0] CPM_M_TOGGLE = 4'h2;
  localparam logic [3:0] CPM_M_CAP_FALL = 4'h4;
  localparam logic [3:0] CPM_M_CAP_RISE = 4'h5;
  localparam logic [3:0] CPM_M_CAP_4 = 4'h6;
  localparam logic [3:0] CPM_M_CAP_16 = 4'h7;
  localparam logic [3:0] CPM_M_SET = 4'h8;
  localparam logic [3:0] CPM_M_CLR = 4'h9;
  localparam logic [3:0] CPM_M_SWI = 4'ha;
  localparam logic [3:0] CPM_M_ADC = 4'hb;
  localparam logic [1:0] CPM_M_PWM_TOP = 2'h3;

  // Period timer prescale codes and the last phase count of each.
  localparam logic [1:0] CPM_PS_1 = 2'h0;
  localparam logic [1:0] CPM_PS_4 = 2'h1;
  localparam logic [1:0] CPM_PS_16 = 2'h2;
  localparam logic [7:0] CPM_LAST_1 = 8'h03;
  localparam logic [7:0] CPM_LAST_4 = 8'h0f;
  localparam logic [7:0] CPM_LAST_16 = 8'h3f;
  localparam logic [7:0] CPM_LAST_64 = 8'hff;
  localparam logic [3:0] CPM_CAP_LAST_4 = 4'h3;
  localparam logic [3:0] CPM_CAP_LAST_16 = 4'hf;

  // Register port request from software.
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cpm_bus_req_t;

endpackage : cpm_pkg

// ===== logic/cpm_pwm_mode_control.sv
`timescale 1ns/10ps

module cpm_pwm_mode_control (
  input wire logic sys_clk, // System clock, 100 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input cpm_pkg::cpm_bus_req_t bus_req, // Register port request.
  output logic [7:0] bus_rdata, // Read data, cycle after read.
  input wire logic sleep, // Device sleeping, freezes unit.
  input wire logic cmp_match, // Compare match pulse, same clock.
  input wire logic trig_sel_hit, // Converter trigger selects us.
  input wire logic cap_pin, // Capture input pin, asynchronous.
  output logic pin_out, // Output pin level.
  output logic pin_oe, // Output pin driver enable.
  output logic irq_flag, // Sticky unit interrupt flag.
  output logic adc_trig, // Converter start pulse.
  output logic cap_event // Capture event pulse.
);
  import cpm_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Registers and state.
  logic [7:0] ctrl;
  logic [7:0] duty_high;
  logic [7:0] shadow;
  logic [1:0] duty_latch;
  logic [7:0] period;
  logic [7:0] count;
  logic [7:0] phase;
  logic [2:0] tctrl;
  logic drive_en;
  logic [3:0] cap_cnt;
  logic cap_s1;
  logic cap_s2;
  logic cap_s3;
  logic cap_lvl;

  //////////////////////////////////////////////////////////////////////////
  // Address decode and mode decode.
  wire wr_ctrl = bus_req.wr && bus_req.addr == CPM_ADDR_CTRL;
  wire wr_duty = bus_req.wr && bus_req.addr == CPM_ADDR_DUTY;
  wire wr_shadow = bus_req.wr && bus_req.addr == CPM_ADDR_SHADOW;
  wire wr_period = bus_req.wr && bus_req.addr == CPM_ADDR_PERIOD;
  wire wr_count = bus_req.wr && bus_req.addr == CPM_ADDR_COUNT;
  wire wr_tctrl = bus_req.wr && bus_req.addr == CPM_ADDR_TCTRL;
  wire wr_status = bus_req.wr && bus_req.addr == CPM_ADDR_STATUS;
  wire wr_pinctl = bus_req.wr && bus_req.addr == CPM_ADDR_PINCTL;
  wire [3:0] mode = ctrl[CPM_MODE_LSB +: 4];
  wire [1:0] duty_low = ctrl[CPM_DLOW_LSB +: 2];
  wire mode_pwm = mode[3:2] == CPM_M_PWM_TOP;
  wire mode_off = mode == CPM_M_OFF;
  wire mode_set = mode == CPM_M_SET;
  wire mode_clr = mode == CPM_M_CLR;
  wire mode_tog = mode == CPM_M_TOGGLE;
  wire mode_swi = mode == CPM_M_SWI;
  wire mode_adc = mode == CPM_M_ADC;
  wire mode_cap = mode[3:2] == 2'h1;
  wire mode_cmp = mode_set || mode_clr || mode_tog || mode_swi || mode_adc;
  wire run = !sleep;

  //////////////////////////////////////////////////////////////////////////
  // Time base. The phase counter divides sys_clk by four times the
  // prescale, so the period follows the system clock directly.
  wire [1:0] ps = tctrl[1:0];
  wire [7:0] phase_last = (ps == CPM_PS_1) ? CPM_LAST_1 :
                          (ps == CPM_PS_4) ? CPM_LAST_4 :
                          (ps == CPM_PS_16) ? CPM_LAST_16 :
                          CPM_LAST_64;
  wire [1:0] ext_bits = (ps == CPM_PS_1) ? phase[1:0] :
                        (ps == CPM_PS_4) ? phase[3:2] :
                        (ps == CPM_PS_16) ? phase[5:4] :
                        phase[7:6];
  wire timer_on = tctrl[CPM_TON_BIT];
  wire tick = run && timer_on && phase == phase_last;
  wire wrap = tick && count == period;
  wire [9:0] time_base = {count, ext_bits};
  wire [9:0] duty_act = {shadow, duty_latch};
  // Compare is a fixed ten bits wide; the period gives log2(4*(period+1)) bits of resolution.
  wire tb_match = time_base == duty_act;
  wire [9:0] duty_next = {duty_high, duty_low};
  wire duty_zero = duty_next == 10'h000;

  // Phase and period counter; both hold while asleep.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase <= CPM_RST_BYTE;
      count <= CPM_RST_BYTE;
    end
    else if (wr_count && run)
    begin
      count <= bus_req.wdata;
      phase <= CPM_RST_BYTE;
    end
    else if (run && timer_on)
    begin
      phase <= (phase == phase_last) ? CPM_RST_BYTE : phase + 8'h01;
      if (wrap)
        count <= CPM_RST_BYTE;
      else if (tick)
        count <= count + 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Software registers. Writes are ignored while asleep, since the
  // module state must not move then.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl <= CPM_RST_BYTE;
      duty_high <= CPM_RST_BYTE;
      period <= CPM_RST_PERIOD;
      tctrl <= CPM_RST_BYTE[2:0];
      drive_en <= 1'b0;
    end
    else if (run)
    begin
      if (wr_ctrl)
        ctrl <= {2'h0, bus_req.wdata[5:0]};
      if (wr_duty)
        duty_high <= bus_req.wdata;
      if (wr_period)
        period <= bus_req.wdata;
      if (wr_tctrl)
        tctrl <= bus_req.wdata[2:0];
      if (wr_pinctl)
        drive_en <= bus_req.wdata[CPM_DRV_BIT];
    end
  end

  // Shadow and hidden latch take the new duty only at period end, so
  // a half-written duty never reaches the comparator.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shadow <= CPM_RST_BYTE;
      duty_latch <= CPM_RST_LOW;
    end
    else if (run)
    begin
      if (mode_pwm && wrap)
      begin
        shadow <= duty_high;
        duty_latch <= duty_low;
      end
      else if (wr_shadow && !mode_pwm)
        shadow <= bus_req.wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Capture input: three stages, a change counts once stages two and
  // three agree.
  wire cap_agree = cap_s2 == cap_s3;
  wire cap_rise = cap_agree && cap_s3 && !cap_lvl;
  wire cap_fall = cap_agree && !cap_s3 && cap_lvl;
  wire cap_last4 = cap_cnt == CPM_CAP_LAST_4;
  wire cap_last16 = cap_cnt == CPM_CAP_LAST_16;
  wire cap_hit = run && (
    (mode == CPM_M_CAP_FALL && cap_fall) ||
    (mode == CPM_M_CAP_RISE && cap_rise) ||
    (mode == CPM_M_CAP_4 && cap_rise && cap_last4) ||
    (mode == CPM_M_CAP_16 && cap_rise && cap_last16));

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cap_s1 <= 1'b0;
      cap_s2 <= 1'b0;
      cap_s3 <= 1'b0;
      cap_lvl <= 1'b0;
    end
    else
    begin
      cap_s1 <= cap_pin;
      cap_s2 <= cap_s1;
      cap_s3 <= cap_s2;
      if (cap_agree && run)
        cap_lvl <= cap_s3;
    end
  end

  // Edge prescale counter; cleared whenever the unit is not capturing.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      cap_cnt <= CPM_RST_NIB;
    else if (!mode_cap)
      cap_cnt <= CPM_RST_NIB;
    else if (run && cap_rise)
      cap_cnt <= cap_hit ? CPM_RST_NIB : cap_cnt + 4'h1;
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin level. Reserved codes 0011 and 0001 leave the pin alone.
  wire cmp_hit = run && mode_cmp && cmp_match;
  logic next_pin;
  always_comb
  begin
    next_pin = pin_out;
    if (!run)
      next_pin = pin_out;
    else if (mode_off)
      next_pin = 1'b0;
    else if (mode_pwm)
    begin
      if (wrap)
        next_pin = !duty_zero;
      else if (tb_match)
        next_pin = 1'b0;
    end
    else if (cmp_hit && mode_set)
      next_pin = 1'b1;
    else if (cmp_hit && mode_clr)
      next_pin = 1'b0;
    else if (cmp_hit && mode_tog)
      next_pin = !pin_out;
  end

  wire pin_driven = mode_pwm || mode_set || mode_clr || mode_tog;
  wire flag_set = cap_hit || cmp_hit;

  // Output flip-flops. A new event wins over a software clear.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
      irq_flag <= 1'b0;
      adc_trig <= 1'b0;
      cap_event <= 1'b0;
    end
    else
    begin
      pin_out <= next_pin;
      pin_oe <= drive_en && pin_driven;
      if (flag_set)
        irq_flag <= 1'b1;
      else if (wr_status && run)
        irq_flag <= bus_req.wdata[CPM_FLAG_BIT];
      adc_trig <= cmp_hit && mode_adc && trig_sel_hit;
      cap_event <= cap_hit;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data, valid only in the cycle after the read strobe.
  logic [7:0] next_rdata;
  always_comb
  begin
    next_rdata = CPM_RST_BYTE;
    if (bus_req.rd)
    begin
      unique case (bus_req.addr)
        CPM_ADDR_CTRL: next_rdata = {2'h0, ctrl[5:0]};
        CPM_ADDR_DUTY: next_rdata = duty_high;
        CPM_ADDR_SHADOW: next_rdata = shadow;
        CPM_ADDR_PERIOD: next_rdata = period;
        CPM_ADDR_COUNT: next_rdata = count;
        CPM_ADDR_TCTRL: next_rdata = {5'h00, tctrl};
        CPM_ADDR_STATUS: next_rdata = {7'h00, irq_flag};
        CPM_ADDR_PINCTL: next_rdata = {7'h00, drive_en};
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      bus_rdata <= CPM_RST_BYTE;
    else
      bus_rdata <= next_rdata;
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks.
  AST_PERIOD_WRAP: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    wrap && !wr_count |=> count == 8'h00)
    else $error("Counter did not clear at period end.");

  AST_SHADOW_LOAD: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    mode_pwm && wrap |=> shadow == $past(duty_high)
      && duty_latch == $past(duty_low))
    else $error("Duty not copied into buffer at period end.");

  AST_MATCH_LOW: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    run && mode_pwm && tb_match && !wrap |=> !pin_out)
    else $error("Output not cleared on duty match.");

  AST_PERIOD_SET: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    run && mode_pwm && wrap |=> pin_out == !$past(duty_zero))
    else $error("Output wrong at period start.");

  AST_SLEEP_HOLD: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    sleep |=> $stable(count) && $stable(pin_out) && $stable(shadow))
    else $error("State moved during sleep.");

  AST_CTRL_TOP: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    bus_req.rd && bus_req.addr == CPM_ADDR_CTRL |=> bus_rdata[7:6] == 2'h0)
    else $error("Control top bits read nonzero.");

  AST_SWI_PIN: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    run && mode_swi && cmp_match |=> irq_flag && $stable(pin_out))
    else $error("Software interrupt mode touched the pin.");

  AST_CMP_SET: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    run && mode_set && cmp_match |=> pin_out && irq_flag)
    else $error("Set on match failed.");

  AST_CMP_TOGGLE: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    run && mode_tog && cmp_match |=> pin_out != $past(pin_out))
    else $error("Toggle on match failed.");

  AST_OFF_LOW: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    run && mode_off |=> !pin_out && !pin_oe)
    else $error("Off mode left the pin active.");

  AST_SHADOW_RO: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    mode_pwm && wr_shadow && !wrap |=> $stable(shadow))
    else $error("Shadow written while PWM active.");

  AST_ADC_TRIG: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    run && mode_adc && cmp_match && trig_sel_hit |=> adc_trig ##1 !adc_trig
      or adc_trig)
    else $error("Converter trigger missing.");

  AST_CMP_CLEAR: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    run && mode_clr && cmp_match |=> !pin_out && irq_flag)
    else $error("Clear on match failed.");

  AST_RESERVED_IDLE: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    run && !(mode_pwm || mode_cmp || mode_off || mode_cap)
      |=> $stable(pin_out) && !pin_oe)
    else $error("Reserved mode touched the pin.");

  AST_CAPTURE_FLAG: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    cap_hit |=> cap_event && irq_flag)
    else $error("Capture event did not raise the flag.");

endmodule : cpm_pwm_mode_control

// ===== verif/cpm_pwm_load.sv
`timescale 1ns/10ps

// Load on the unit's output pin; it times each pulse and each period.
module cpm_pwm_load (
  input wire logic sys_clk, // System clock.
  input wire logic pin_out, // Pin level from the unit.
  input wire logic pin_oe, // Pin driver enable.
  output logic [11:0] hi_len, // Last high time in cycles.
  output logic [11:0] per_len // Last rise-to-rise time in cycles.
);
  logic lvl;
  logic lvl_q = 1'b0;
  logic [11:0] cnt = 12'h000;
  logic [11:0] hcnt = 12'h000;

  // A pull-down holds the line low whenever the unit lets go of it.
  assign lvl = pin_oe & pin_out;

  //////////////////////////////////////////////////////////////////////////////
  // Lengths are kept in clocks, so a slower clock stretches them alike.
  always @(posedge sys_clk)
  begin
    lvl_q <= lvl;
    cnt <= cnt + 12'h001;
    hcnt <= lvl ? hcnt + 12'h001 : 12'h000;
    if (lvl && !lvl_q)
    begin
      per_len <= cnt;
      cnt <= 12'h001;
    end
    if (!lvl && lvl_q)
      hi_len <= hcnt;
  end
endmodule : cpm_pwm_load

// ===== verif/cpm_pwm_mode_control_test.sv
`timescale 1ns/10ps

// Bench: register tasks, then tests built from calls with expected values.
module cpm_pwm_mode_control_test;
  import cpm_pkg::*;
  // The pin falls one clock after the cycle in which the time base matches.
  localparam int PIN_LAT = 1;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  cpm_bus_req_t bus_req = '0;
  logic [7:0] bus_rdata;
  logic sleep = 1'b0;
  logic cmp_match = 1'b0;
  logic trig_sel_hit = 1'b1;
  logic cap_pin = 1'b0;
  logic pin_out, pin_oe, irq_flag, adc_trig, cap_event;
  logic [11:0] hi_len, per_len;
  logic [7:0] v, w;
  logic b;
  logic [3:0] cm [6] = '{4'h8, 4'h9, 4'h2, 4'ha, 4'hb, 4'hb};
  logic [2:0] cx [6] = '{3'h3, 3'h2, 3'h3, 3'h0, 3'h4, 3'h0};
  logic [3:0] pm [4] = '{4'h4, 4'h5, 4'h6, 4'h7};
  int pn [4] = '{4, 4, 8, 16};
  int pe [4] = '{4, 4, 2, 1};
  int err_count = 0;
  int num_checks = 0;
  int ev = 0;
  int ev0 = 0;

  always #5 sys_clk = ~sys_clk;

  cpm_pwm_mode_control DUT (.sys_clk(sys_clk), .rst_n(rst_n),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .sleep(sleep),
    .cmp_match(cmp_match), .trig_sel_hit(trig_sel_hit), .cap_pin(cap_pin),
    .pin_out(pin_out), .pin_oe(pin_oe), .irq_flag(irq_flag),
    .adc_trig(adc_trig), .cap_event(cap_event));

  cpm_pwm_load load (.sys_clk(sys_clk), .pin_out(pin_out),
    .pin_oe(pin_oe), .hi_len(hi_len), .per_len(per_len));

  // Capture pulses are tallied as they come.
  always @(posedge sys_clk)
    if (cap_event === 1'b1)
      ev <= ev + 1;

  //////////////////////////////////////////////////////////////////////////////
  task print_verdict;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  task chk(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe.
  task rd(input logic [2:0] a);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1 v = bus_rdata;
  endtask : rd

  task rchk(input logic [2:0] a, input logic [7:0] e);
    rd(a);
    chk({4'h0, v}, {4'h0, e});
  endtask : rchk

  task steady(input logic e);
    repeat (16)
    begin
      @(posedge sys_clk);
      #1 chk({11'h0, pin_out}, {11'h0, e});
    end
  endtask : steady

  // The mode's low bits follow the prescale, so every 11xx code is used.
  task pwm(input logic [7:0] p, input logic [1:0] ps, input logic [9:0] d);
    int sc;
    int per;
    sc = 1 << (2 * ps);
    per = (p + 1) * 4 * sc;
    wr(CPM_ADDR_PERIOD, p);
    wr(CPM_ADDR_DUTY, d[9:2]);
    wr(CPM_ADDR_CTRL, {2'b00, d[1:0], 2'b11, ps});
    wr(CPM_ADDR_TCTRL, {6'h01, ps});
    // Restarting the counter also restarts the phase, so a shorter period
    // or a faster prescale never waits for a long roll-over.
    wr(CPM_ADDR_COUNT, 8'h00);
    wr(CPM_ADDR_PINCTL, 8'h01);
    repeat (3 * per) @(posedge sys_clk);
    chk(per_len, 12'(per));
    chk(hi_len, 12'(d * sc + PIN_LAT));
  endtask : pwm

  initial
  begin
    repeat (40000) @(posedge sys_clk);
    err_count++;
    print_verdict();
  end

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    @(posedge sys_clk);
    #1 chk({11'h0, pin_oe}, 12'h000);
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rchk(CPM_ADDR_CTRL, 8'h00);
    rchk(CPM_ADDR_PERIOD, 8'hff);
    wr(CPM_ADDR_CTRL, 8'hf2);
    rchk(CPM_ADDR_CTRL, 8'h32);
    pwm(8'hff, 2'h0, 10'h201);
    for (int i = 3; i >= 0; i--)
      pwm(8'h03, 2'(i), 10'h006);
    // Duty written mid-period waits for the wrap; the shadow stays put.
    wr(CPM_ADDR_DUTY, 8'h02);
    rchk(CPM_ADDR_SHADOW, 8'h01);
    wr(CPM_ADDR_SHADOW, 8'h3f);
    repeat (20) @(posedge sys_clk);
    rchk(CPM_ADDR_SHADOW, 8'h02);
    repeat (48) @(posedge sys_clk);
    chk(hi_len, 12'(10 + PIN_LAT));
    // Sleep freezes counter, pin and registers.
    sleep <= 1'b1;
    rd(CPM_ADDR_COUNT);
    w = v;
    b = pin_out;
    wr(CPM_ADDR_PERIOD, 8'h20);
    steady(b);
    rchk(CPM_ADDR_COUNT, w);
    sleep <= 1'b0;
    rchk(CPM_ADDR_PERIOD, 8'h03);
    wr(CPM_ADDR_DUTY, 8'h10);
    repeat (40) @(posedge sys_clk);
    steady(1'b1);
    // Switching off while the pin is high must pull it low and release it.
    wr(CPM_ADDR_CTRL, 8'h00);
    repeat (2) @(posedge sys_clk);
    #1 chk({11'h0, pin_out}, 12'h000);
    chk({11'h0, pin_oe}, 12'h000);
    wr(CPM_ADDR_DUTY, 8'h00);
    wr(CPM_ADDR_CTRL, 8'h0c);
    repeat (40) @(posedge sys_clk);
    steady(1'b0);
    // Each compare action: flag, pin, driver and converter start.
    // The last entry repeats the converter mode with its selection off.
    for (int i = 0; i < 6; i++)
    begin
      wr(CPM_ADDR_CTRL, {4'h0, cm[i]});
      trig_sel_hit <= (i < 5);
      wr(CPM_ADDR_STATUS, 8'h00);
      #1 chk({11'h0, irq_flag}, 12'h000);
      @(posedge sys_clk);
      cmp_match <= 1'b1;
      @(posedge sys_clk);
      cmp_match <= 1'b0;
      #1 chk({11'h0, irq_flag}, 12'h001);
      chk({11'h0, adc_trig}, {11'h0, cx[i][2]});
      chk({11'h0, pin_oe}, {11'h0, cx[i][1]});
      if (cx[i][1])
        chk({11'h0, pin_out}, {11'h0, cx[i][0]});
      rchk(CPM_ADDR_STATUS, 8'h01);
    end
    // Capture edges and prescale, counted over a train of pulses.
    for (int i = 0; i < 4; i++)
    begin
      wr(CPM_ADDR_CTRL, {4'h0, pm[i]});
      repeat (8) @(posedge sys_clk);
      ev0 = ev;
      repeat (pn[i])
      begin
        @(posedge sys_clk);
        cap_pin <= 1'b1;
        repeat (8) @(posedge sys_clk);
        cap_pin <= 1'b0;
        repeat (8) @(posedge sys_clk);
      end
      chk(12'(ev - ev0), 12'(pe[i]));
    end
    wr(CPM_ADDR_CTRL, 8'h03);
    repeat (2) @(posedge sys_clk);
    #1 chk({11'h0, pin_oe}, 12'h000);
    wr(CPM_ADDR_CTRL, 8'h08);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    #1 chk({11'h0, pin_oe}, 12'h000);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    rchk(CPM_ADDR_CTRL, 8'h00);
    print_verdict();
  end
endmodule : cpm_pwm_mode_control_test
